// >>> src/gpt_pkg.sv
// Package for the gated pulse totalizer: map, fields, reset values, timing
package gpt_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFF_CTRL      = 8'h00;
    localparam logic [7:0] OFF_COUNT     = 8'h04;
    localparam logic [7:0] OFF_COUNT_RC  = 8'h08;
    localparam logic [7:0] OFF_MON       = 8'h0c;
    localparam logic [7:0] OFF_LIMIT     = 8'h10;
    localparam logic [7:0] OFF_CMD       = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN    = 8'h1c;
    localparam logic [7:0] OFF_IRQ_CLR   = 8'h20;
    localparam logic [7:0] OFF_INFO      = 8'h24;

    // Control fields
    localparam int CTRL_FALL_BIT   = 0;
    localparam int CTRL_RRC_BIT    = 1;
    localparam int CTRL_ALM_EN_BIT = 2;
    localparam int CTRL_ALM_LO     = 4;
    localparam int CTRL_ALM_W      = 2;
    localparam int CTRL_FMT_LO     = 8;
    localparam int CTRL_FMT_W      = 3;

    // Command fields (write-only)
    localparam int CMD_CLEAR_BIT  = 0;
    localparam int CMD_REINIT_BIT = 1;

    // Interrupt status fields
    localparam int IRQ_ALARM_BIT = 0;
    localparam int IRQ_WRAP_BIT  = 1;
    localparam int IRQ_W         = 2;

    // Sizes and reset values
    localparam int          CNT_W       = 26;
    localparam logic [25:0] CNT_MAX     = 26'h3ffffff;
    localparam logic [25:0] CNT_RST     = 26'h0000000;
    localparam logic [25:0] LIMIT_RST   = 26'h3ffffff;
    localparam logic [7:0]  CHAN_POS    = 8'h03;
    localparam logic [15:0] STAMP_RST   = 16'h0000;

    // Input rate versus clock: at least this many samples per input period
    localparam int CLK_MHZ        = 250;
    localparam int MAX_IN_KHZ     = 100;
    localparam int SAMPLES_PER_IN = (CLK_MHZ * 1000) / MAX_IN_KHZ;

    // Bus port
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } gpt_bus_req_t;

    // Field state
    typedef struct packed {
        logic       fall_sel;
        logic       rrc_mode;
        logic       alm_en;
        logic [1:0] alm_num;
        logic [2:0] fmt;
    } gpt_cfg_t;

endpackage : gpt_pkg

// >>> src/gpt_totalizer.sv
// Gated pulse totalizer: 26-bit edge counter with gates, alarm, bus regs
// Operation
// - Keep a 26-bit count; catch every input edge up to 100 kHz.
// - Channel position 03 is reported in INFO reads when format bit 1 is set.
// - Configuration picks rising or falling input edge to count.
// - High-active gate allows counting only while high.
// - Low-active gate allows counting only while low.
// - Count only while both gates enable; either may be used alone.
// - Unwired gate floats to its enabling level, always permitting counts.
// - A qualified edge at 67,108,863 wraps the count to zero.
// - Read-and-clear read returns count, clears it, loses no edge.
// - Scan sweep reads clear the count in read-and-clear mode.
// - Direct queries (COUNT reads) do not clear the count, even in read-and-clear mode.
// - Monitor reads never clear the count.
// - Enabled count alarm is checked every cycle, scanning or not.
// - Preset, factory reset or card reinit force the count to zero.
// - Immediate clear request zeroes the count at once.
// - Reads may carry stamp, channel and alarm status per format.
// - Upper-limit alarm with its own enable, on one of four numbers.
module gpt_totalizer (
    // Clock, reset, enable
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // Register port
    input  wire gpt_pkg::gpt_bus_req_t bus_req,
    output logic [31:0]               bus_rdata,
    // Field inputs
    input  wire logic                 pulse_in,
    input  wire logic                 gate_hi_en,
    input  wire logic                 gate_lo_en_n,
    input  wire logic                 preset_req,
    input  wire logic [15:0]          time_stamp,
    // Status outputs
    output logic [3:0]                alarm_lines,
    output logic                      irq
);

    typedef struct packed {
        logic [1:0]      pulse_s;
        logic [1:0]      ghi_s;
        logic [1:0]      glo_s;
        logic            pulse_prev;
        logic [25:0]     count;
        logic [25:0]     limit;
        gpt_pkg::gpt_cfg_t cfg;
        logic            alarm;
        logic [1:0]      irq_stat;
        logic [1:0]      irq_en;
        logic [31:0]     rdata;
        logic [3:0]      alines;
        logic            irq;
    } gpt_state_t;

    gpt_state_t s_q;
    gpt_state_t s_d;

    // Address match helper, used for every register decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    // Formatted read word: count in low bits, alarm status in bit 31 by format bit 2
    function automatic logic [31:0] fmt_word(input logic [25:0] c,
                                             input logic [2:0] f,
                                             input logic al);
        fmt_word = {6'h00, c};
        if (f[2]) begin
            fmt_word[31] = al;
        end
    endfunction : fmt_word

    logic        edge_seen;
    logic        gate_ok;
    logic        rd_clear;
    logic        wr_ctrl;
    logic [31:0] wd;
    logic [7:0]  ad;

    // Next-state logic
    always_comb begin
        s_d = s_q;
        ad  = bus_req.addr;
        wd  = bus_req.wdata;

        // Two-flop synchronisers; first stage feeds second only
        s_d.pulse_s = {s_q.pulse_s[0], pulse_in};
        s_d.ghi_s   = {s_q.ghi_s[0], gate_hi_en};
        s_d.glo_s   = {s_q.glo_s[0], gate_lo_en_n};
        s_d.pulse_prev = s_q.pulse_s[1];

        // Edge pick: 250 MHz sampling far outpaces 100 kHz input
        edge_seen = s_q.cfg.fall_sel
            ? (s_q.pulse_prev & ~s_q.pulse_s[1])
            : (~s_q.pulse_prev & s_q.pulse_s[1]);
        // Board pull resistors bias open gates to enable
        gate_ok = s_q.ghi_s[1]
            & ~s_q.glo_s[1];

        rd_clear = bus_req.rd & hit(ad, gpt_pkg::OFF_COUNT_RC)
            & s_q.cfg.rrc_mode;

        // Read data, one cycle later
        s_d.rdata = 32'h0000_0000;
        if (bus_req.rd) begin
            if (hit(ad, gpt_pkg::OFF_CTRL)) begin
                s_d.rdata = {21'h000000, s_q.cfg.fmt, 2'h0,
                    s_q.cfg.alm_num, 1'b0, s_q.cfg.alm_en,
                    s_q.cfg.rrc_mode, s_q.cfg.fall_sel};
            end else if (hit(ad, gpt_pkg::OFF_COUNT)
                         || hit(ad, gpt_pkg::OFF_COUNT_RC)) begin
                s_d.rdata = fmt_word(s_q.count, s_q.cfg.fmt, s_q.alarm);
            end else if (hit(ad, gpt_pkg::OFF_MON)) begin
                s_d.rdata = {6'h00, s_q.count};
            end else if (hit(ad, gpt_pkg::OFF_LIMIT)) begin
                s_d.rdata = {6'h00, s_q.limit};
            end else if (hit(ad, gpt_pkg::OFF_IRQ_STAT)) begin
                s_d.rdata = {30'h00000000, s_q.irq_stat};
            end else if (hit(ad, gpt_pkg::OFF_IRQ_EN)) begin
                s_d.rdata = {30'h00000000, s_q.irq_en};
            end else if (hit(ad, gpt_pkg::OFF_INFO)) begin
                // Stamp follows format bit 0, channel follows format bit 1, each on its own
                s_d.rdata = {8'h00,
                    s_q.cfg.fmt[0] ? time_stamp : gpt_pkg::STAMP_RST,
                    s_q.cfg.fmt[1] ? gpt_pkg::CHAN_POS : 8'h00};
            end
        end

        // Register writes
        wr_ctrl = bus_req.wr & hit(ad, gpt_pkg::OFF_CTRL);
        if (wr_ctrl) begin
            s_d.cfg.fall_sel = wd[gpt_pkg::CTRL_FALL_BIT];
            s_d.cfg.rrc_mode = wd[gpt_pkg::CTRL_RRC_BIT];
            s_d.cfg.alm_en   = wd[gpt_pkg::CTRL_ALM_EN_BIT];
            s_d.cfg.alm_num  = wd[gpt_pkg::CTRL_ALM_LO +: gpt_pkg::CTRL_ALM_W];
            s_d.cfg.fmt      = wd[gpt_pkg::CTRL_FMT_LO +: gpt_pkg::CTRL_FMT_W];
        end
        if (bus_req.wr && hit(ad, gpt_pkg::OFF_LIMIT)) begin
            s_d.limit = wd[25:0];
        end
        if (bus_req.wr && hit(ad, gpt_pkg::OFF_IRQ_EN)) begin
            s_d.irq_en = wd[1:0];
        end

        // Count: clear sources first, then a surviving edge adds one.
        // An edge in the clearing cycle starts the new count at one.
        if ((bus_req.wr && hit(ad, gpt_pkg::OFF_CMD)
             && (wd[gpt_pkg::CMD_CLEAR_BIT] || wd[gpt_pkg::CMD_REINIT_BIT]))
            || preset_req) begin
            s_d.count = gpt_pkg::CNT_RST;
        end else if (rd_clear) begin
            s_d.count = gpt_pkg::CNT_RST;
        end
        if (edge_seen && gate_ok) begin
            if (s_q.count == gpt_pkg::CNT_MAX
                && !((bus_req.wr && hit(ad, gpt_pkg::OFF_CMD)) || preset_req
                     || rd_clear)) begin
                s_d.count = gpt_pkg::CNT_RST;
            end else begin
                s_d.count = s_d.count + 26'h0000001;
            end
        end
        // Card reinit restores configuration as well
        if (bus_req.wr && hit(ad, gpt_pkg::OFF_CMD)
            && wd[gpt_pkg::CMD_REINIT_BIT]) begin
            s_d.cfg   = '0;
            s_d.limit = gpt_pkg::LIMIT_RST;
        end

        // Alarm evaluated every cycle on live count
        s_d.alarm = s_q.cfg.alm_en && (s_q.count >= s_q.limit);
        s_d.alines = 4'h0;
        s_d.alines[s_q.cfg.alm_num] = s_q.alarm;

        // Sticky interrupt status; set beats clear
        if (bus_req.wr && hit(ad, gpt_pkg::OFF_IRQ_CLR)) begin
            s_d.irq_stat = s_q.irq_stat & ~wd[1:0];
        end
        if (s_q.alarm) begin
            s_d.irq_stat[gpt_pkg::IRQ_ALARM_BIT] = 1'b1;
        end
        if (edge_seen && gate_ok && s_q.count == gpt_pkg::CNT_MAX) begin
            s_d.irq_stat[gpt_pkg::IRQ_WRAP_BIT] = 1'b1;
        end
        s_d.irq = |(s_q.irq_stat & s_q.irq_en);
    end

    // State register; clock enable freezes all
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q       <= '0;
            s_q.limit <= gpt_pkg::LIMIT_RST;
            s_q.count <= gpt_pkg::CNT_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign bus_rdata   = s_q.rdata;
    assign alarm_lines = s_q.alines;
    assign irq         = s_q.irq;

endmodule : gpt_totalizer

// >>> verif/gpt_totalizer_assertions.sv
// Concurrent checks on the totalizer ports
module gpt_totalizer_chk (
    // Clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst,
    input wire logic                  clk_en,
    // Bus and status
    input wire gpt_pkg::gpt_bus_req_t bus_req,
    input wire logic [31:0]           bus_rdata,
    input wire logic                  preset_req,
    input wire logic [3:0]            alarm_lines,
    input wire logic                  irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Decoded strobes
    logic rd_cnt;
    logic wr_cmd;
    assign rd_cnt = bus_req.rd && bus_req.addr == gpt_pkg::OFF_COUNT;
    assign wr_cmd = bus_req.wr && bus_req.addr == gpt_pkg::OFF_CMD;
    a_rdata_idle: assert property (clk_en && !bus_req.rd |=>
        bus_rdata == 32'h0) else $error("read data outside slot");
    a_unmapped_zero: assert property (bus_req.rd &&
        bus_req.addr > gpt_pkg::OFF_INFO |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_clear_zero: assert property (wr_cmd && bus_req.wdata[0]
        ##2 rd_cnt |=> bus_rdata < 32'h4) else $error("clear missed");
    a_preset_zero: assert property (preset_req ##2 rd_cnt |=>
        bus_rdata < 32'h4) else $error("preset missed");
    a_reinit_limit: assert property (wr_cmd && bus_req.wdata[1]
        ##2 bus_req.rd && bus_req.addr == gpt_pkg::OFF_LIMIT |=>
        bus_rdata[25:0] == gpt_pkg::LIMIT_RST) else $error("limit kept");
    a_irq_masked: assert property (bus_req.wr &&
        bus_req.addr == gpt_pkg::OFF_IRQ_EN && bus_req.wdata[1:0] == 2'h0
        ##1 !bus_req.wr |=> !irq) else $error("masked irq high");
    a_alarm_off: assert property (bus_req.wr &&
        bus_req.addr == gpt_pkg::OFF_CTRL && !bus_req.wdata[2]
        ##1 !bus_req.wr [*2] |=> alarm_lines == 4'h0)
        else $error("alarm line after disable");
    a_line_onehot: assert property ($onehot0(alarm_lines))
        else $error("several alarm lines");
endmodule : gpt_totalizer_chk

bind gpt_totalizer gpt_totalizer_chk i_chk (.ref_clk, .rst, .clk_en,
    .bus_req, .bus_rdata, .preset_req, .alarm_lines, .irq);

// >>> verif/gpt_pulse_src.sv
// Pulse source and gate drivers on the field side
module gpt_pulse_src #(
    parameter int HALF = 4
) (
    // Clock
    input  wire logic ref_clk,
    // Field lines
    output logic      pulse_in,
    output logic      gate_hi_en,
    output logic      gate_lo_en_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Unwired gates rest at their enabling level
    initial begin
        pulse_in     = 1'b0;
        gate_hi_en   = 1'b1;
        gate_lo_en_n = 1'b0;
    end
    // Hold each level HALF+1 cycles, enough for the synchroniser
    task automatic level(input logic v);
        @(posedge ref_clk);
        pulse_in <= v;
        repeat (HALF) @(posedge ref_clk);
    endtask : level
    // Faster than field rate to keep the run short
    task automatic burst(input int n);
        repeat (n) begin
            level(1'b1);
            level(1'b0);
        end
    endtask : burst
    task automatic gates(input logic h, input logic ln);
        @(posedge ref_clk);
        gate_hi_en   <= h;
        gate_lo_en_n <= ln;
        repeat (HALF) @(posedge ref_clk);
    endtask : gates
endmodule : gpt_pulse_src

// >>> verif/gpt_totalizer_tb.sv
// Self-checking bench for the gated pulse totalizer
module gpt_totalizer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  ref_clk = 1'b0;
    logic                  rst = 1'b1;
    gpt_pkg::gpt_bus_req_t req = '0;
    logic [31:0]           rdata;
    logic                  pulse_in, gate_hi_en, gate_lo_en_n;
    logic                  preset_req = 1'b0;
    logic                  clk_en = 1'b1;
    logic [15:0]           stamp = 16'h5a3c;
    logic [3:0]            alarm_lines;
    logic                  irq;
    int                    error_cnt = 0;
    int                    total_checks = 0;
    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;
    gpt_totalizer i_gpt_totalizer (.ref_clk(ref_clk), .rst(rst),
        .clk_en(clk_en), .bus_req(req), .bus_rdata(rdata),
        .pulse_in(pulse_in), .gate_hi_en(gate_hi_en),
        .gate_lo_en_n(gate_lo_en_n), .preset_req(preset_req),
        .time_stamp(stamp), .alarm_lines(alarm_lines), .irq(irq));
    gpt_pulse_src i_gpt_pulse_src (.ref_clk(ref_clk), .pulse_in(pulse_in),
        .gate_hi_en(gate_hi_en), .gate_lo_en_n(gate_lo_en_n));
    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 chk(n, rdata, e);
    endtask : rc
    task automatic t_count;
        rc("limit", gpt_pkg::OFF_LIMIT, 32'h3ffffff);
        i_gpt_pulse_src.burst(5);
        rc("count", gpt_pkg::OFF_COUNT, 32'h5);
        rc("count", gpt_pkg::OFF_COUNT, 32'h5);
        wr(gpt_pkg::OFF_CTRL, 32'h2);
        rc("mon", gpt_pkg::OFF_MON, 32'h5);
        rc("rc", gpt_pkg::OFF_COUNT_RC, 32'h5);
        rc("count", gpt_pkg::OFF_COUNT, 32'h0);
        i_gpt_pulse_src.burst(3);
        rc("rc", gpt_pkg::OFF_COUNT_RC, 32'h3);
        wr(gpt_pkg::OFF_CTRL, 32'h1);
        i_gpt_pulse_src.level(1'b1);
        rc("rise", gpt_pkg::OFF_COUNT, 32'h0);
        i_gpt_pulse_src.level(1'b0);
        rc("fall", gpt_pkg::OFF_COUNT, 32'h1);
        wr(gpt_pkg::OFF_CTRL, 32'h0);
    endtask : t_count
    task automatic t_gates;
        i_gpt_pulse_src.gates(1'b0, 1'b0);
        i_gpt_pulse_src.burst(3);
        rc("g_hi", gpt_pkg::OFF_COUNT, 32'h1);
        i_gpt_pulse_src.gates(1'b1, 1'b1);
        i_gpt_pulse_src.burst(3);
        rc("g_lo", gpt_pkg::OFF_COUNT, 32'h1);
        i_gpt_pulse_src.gates(1'b1, 1'b0);
        i_gpt_pulse_src.burst(2);
        rc("g_both", gpt_pkg::OFF_COUNT, 32'h3);
    endtask : t_gates
    // Enable low freezes all state, so pulses meanwhile are not counted
    task automatic t_freeze;
        @(posedge ref_clk) clk_en <= 1'b0;
        i_gpt_pulse_src.burst(2);
        @(posedge ref_clk) clk_en <= 1'b1;
        rc("frozen", gpt_pkg::OFF_COUNT, 32'h3);
    endtask : t_freeze
    task automatic t_clear;
        wr(gpt_pkg::OFF_CMD, 32'h1);
        rc("clr", gpt_pkg::OFF_COUNT, 32'h0);
        i_gpt_pulse_src.burst(2);
        @(posedge ref_clk) preset_req <= 1'b1;
        @(posedge ref_clk) preset_req <= 1'b0;
        rc("preset", gpt_pkg::OFF_COUNT, 32'h0);
        wr(gpt_pkg::OFF_LIMIT, 32'h7);
        i_gpt_pulse_src.burst(2);
        wr(gpt_pkg::OFF_CMD, 32'h2);
        rc("limit", gpt_pkg::OFF_LIMIT, 32'h3ffffff);
        rc("reinit", gpt_pkg::OFF_COUNT, 32'h0);
    endtask : t_clear
    task automatic t_alarm;
        wr(gpt_pkg::OFF_LIMIT, 32'h2);
        wr(gpt_pkg::OFF_IRQ_EN, 32'h1);
        wr(gpt_pkg::OFF_CTRL, 32'h24);
        i_gpt_pulse_src.burst(2);
        repeat (4) @(posedge ref_clk);
        chk("lines", {28'h0, alarm_lines}, 32'h4);
        chk("irq", {31'h0, irq}, 32'h1);
        rc("stat", gpt_pkg::OFF_IRQ_STAT, 32'h1);
        wr(gpt_pkg::OFF_IRQ_EN, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("mask", {31'h0, irq}, 32'h0);
        wr(gpt_pkg::OFF_CTRL, 32'h700);
        wr(gpt_pkg::OFF_IRQ_CLR, 32'h3);
        wr(gpt_pkg::OFF_IRQ_EN, 32'h1);
        rc("stat", gpt_pkg::OFF_IRQ_STAT, 32'h0);
        chk("off", {27'h0, alarm_lines, irq}, 32'h0);
        rc("info", gpt_pkg::OFF_INFO, 32'h5a3c03);
        rc("hole", 8'h40, 32'h0);
    endtask : t_alarm
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #80000;
        error_cnt++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        t_count();
        t_gates();
        t_freeze();
        t_clear();
        t_alarm();
        give_verdict();
    end
endmodule : gpt_totalizer_tb
